// [rtl/cci_pkg.sv]
// constants and entry layouts of the configuration cache invalidation block
// Function
// - partition-map invalidate clears only the separate partition-map cache by security and vm tag
// - partition-map invalidate errors if no monitor support, no interface support, bad select
// - invalidate-all equals range 31 over all source ids, source id ignored
// - invalidate-all also drops vm structure, stream, pointer and context caching
// - security select 1 from the non-secure queue raises the illegal-command error for configuration and partition-map commands only
// - invalidate-all is detected and done as one full clear
// - invalidations never touch stalled transactions
// - a retried stalled transaction translates afresh with current structures
// - each entry invalidation is atomic; in-flight users may finish
// - sync completes only after prior invalidations and in-flight users are done
// - tlb invalidates act on the local tlb only, no broadcast
// - with 8-bit tags, nonzero upper tag bits make the tlb command a no-op
// - address-space tag matching ignores the shared-set flag
// - locked tlb entries are kept; no over-invalidation
// - address match ignores low bits spanned by the entry size
// - one id bit reports range invalidation and level hint support
// - leaf-only scope removes only last-level entries
// - vm wildcard enable per security state widens vm tag matching
// - security select 0 is non-secure, 1 is secure
package cci_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CMD0   = 8'h04;
    localparam logic [7:0] REG_SID    = 8'h08;
    localparam logic [7:0] REG_TAGS   = 8'h0c;
    localparam logic [7:0] REG_ADDR   = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_ID     = 8'h18;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_NS_WILD = 0;
    localparam int CTRL_S_WILD  = 1;
    localparam int CTRL_SECQ    = 2;
    localparam int CMD0_SEL     = 8;
    localparam int CMD0_LEAF    = 9;
    localparam int CMD0_RANGE   = 10;
    localparam int CMD0_SUB     = 12;
    localparam int ST_ERR       = 0;
    localparam int ST_BUSY      = 1;
    localparam int ST_SYNC      = 16;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // ------------------------------------------------------------
    // command opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_STE     = 8'h01;
    localparam logic [7:0] OP_STE_RNG = 8'h02;
    localparam logic [7:0] OP_CD      = 8'h03;
    localparam logic [7:0] OP_CD_ALL  = 8'h04;
    localparam logic [7:0] OP_ALL     = 8'h05;
    localparam logic [7:0] OP_PMAP    = 8'h06;
    localparam logic [7:0] OP_TLB_SEC = 8'h10;
    localparam logic [7:0] OP_TLB_VM  = 8'h11;
    localparam logic [7:0] OP_TLB_AS  = 8'h12;
    localparam logic [7:0] OP_TLB_VA  = 8'h13;
    localparam logic [7:0] OP_SYNC    = 8'h46;
    localparam logic [4:0] RANGE_ALL  = 5'h1f;
    // ------------------------------------------------------------
    // cached entry kinds and layouts
    // ------------------------------------------------------------
    localparam logic [2:0] K_STE  = 3'h0;
    localparam logic [2:0] K_STREAM_POINTER_DESCRIPTOR = 3'h1;
    localparam logic [2:0] K_CD   = 3'h2;
    localparam logic [2:0] K_CONTEXT_POINTER_DESCRIPTOR = 3'h3;
    localparam logic [2:0] K_VMS  = 3'h4;
    typedef struct packed {
        logic        v;
        logic        sec;
        logic [2:0]  kind;
        logic [31:0] sid;
        logic [19:0] sub;
    } cci_cfg_t;
    typedef struct packed {
        logic        v;
        logic        sec;
        logic [15:0] vm;
    } cci_pm_t;
    typedef struct packed {
        logic        v;
        logic        sec;
        logic        lock;
        logic        leaf;
        logic        wild;
        logic [15:0] vm;
        logic [15:0] address_space_tag;
        logic [31:0] addr;
        logic [4:0]  size;
    } cci_tlb_t;
    typedef enum logic [1:0] {PH_IDLE, PH_EXEC, PH_SYNC} cci_ph_t;
endpackage : cci_pkg

// [rtl/cci_inval.sv]
// configuration cache and tlb invalidation engine with apb register access
`timescale 1ns/1ps
`default_nettype none
module cci_inval #(
    parameter int NCFG      = 8,
    parameter int NPM       = 4,
    parameter int NTLB      = 8,
    parameter bit PM_SUP    = 1'b1,
    parameter bit PM_NS_IF  = 1'b1,
    parameter bit PM_S_IF   = 1'b1,
    parameter bit VMS_NS_IF = 1'b1,
    parameter bit VMS_S_IF  = 1'b1,
    parameter bit RIL_SUP   = 1'b1,
    parameter bit ASID16    = 1'b1,
    parameter bit VMID16    = 1'b1,
    parameter bit STAGE1    = 1'b1
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 fill_valid,
    input  wire logic [1:0]           fill_target,
    input  wire logic [7:0]           fill_idx,
    input  wire cci_pkg::cci_cfg_t    fill_cfg,
    input  wire cci_pkg::cci_pm_t     fill_pm,
    input  wire cci_pkg::cci_tlb_t    fill_tlb,
    input  wire logic                 xlat_inflight,
    output logic      [NCFG-1:0]      cfg_valid,
    output logic      [NPM-1:0]       pm_valid,
    output logic      [NTLB-1:0]      tlb_valid,
    output logic                      illegal_command_error,
    output logic                      sync_done
);
    import cci_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                 ns_wild;
        logic                 s_wild;
        logic                 secq;
        logic [31:0]          cmd0;
        logic [31:0]          sid;
        logic [31:0]          tags;
        logic [31:0]          addr;
        cci_ph_t              ph;
        logic                 err;
        logic                 sync_pulse;
        logic [15:0]          sync_cnt;
        logic [31:0]          rdata;
        logic                 rdy;
        logic                 slverr;
        cci_cfg_t [NCFG-1:0]  cfg;
        cci_pm_t  [NPM-1:0]   pm;
        cci_tlb_t [NTLB-1:0]  tlb;
    } cci_st_t;

    cci_st_t st_ff;
    cci_st_t nxt_st;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic [7:0]  op;
    logic        csel;
    logic        cleaf;
    logic [4:0]  crng;
    logic [19:0] csub;
    logic [15:0] cvm;
    logic [15:0] cas;
    logic [32:0] rmask;
    logic        sel_bad;
    logic        pm_if_ok;
    logic        tag_bad;
    logic        is_cfg_op;
    logic        is_tlb_op;
    logic        illegal;

    // field split of the staged command
    assign op    = st_ff.cmd0[7:0];
    assign csel  = st_ff.cmd0[CMD0_SEL];
    assign cleaf = st_ff.cmd0[CMD0_LEAF];
    assign crng  = st_ff.cmd0[CMD0_RANGE +: 5];
    assign csub  = st_ff.cmd0[CMD0_SUB +: 20];
    assign cvm   = st_ff.tags[15:0];
    assign cas   = st_ff.tags[31:16];
    // aligned source id range; range 31 leaves no bit compared
    assign rmask = ~((33'd1 << (6'(crng) + 6'd1)) - 33'd1);

    // error screening of the staged command
    assign is_cfg_op = (op == OP_STE) || (op == OP_STE_RNG) || (op == OP_CD)
                     || (op == OP_CD_ALL) || (op == OP_ALL) || (op == OP_PMAP);
    assign is_tlb_op = (op == OP_TLB_SEC) || (op == OP_TLB_VM)
                     || (op == OP_TLB_AS) || (op == OP_TLB_VA);
    assign sel_bad   = csel && !st_ff.secq;
    assign pm_if_ok  = csel ? (PM_S_IF && VMS_S_IF) : (PM_NS_IF && VMS_NS_IF);
    assign tag_bad   = (!VMID16 && (cvm[15:8] != 8'h00))
                     || (!ASID16 && (cas[15:8] != 8'h00));
    always_comb begin
        illegal = 1'b0;
        if (!is_cfg_op && !is_tlb_op && (op != OP_SYNC)) begin
            illegal = 1'b1;
        end else if (is_cfg_op && sel_bad) begin
            illegal = 1'b1;
        end else if (op == OP_PMAP && (!PM_SUP || !pm_if_ok)) begin
            illegal = 1'b1;
        end else if ((op == OP_CD || op == OP_CD_ALL) && !STAGE1) begin
            illegal = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // per-entry match of the staged command
    // ------------------------------------------------------------
    logic [NCFG-1:0] cfg_hit;
    logic [NPM-1:0]  pm_hit;
    logic [NTLB-1:0] tlb_hit;

    genvar gi;
    generate
        for (gi = 0; gi < NCFG; gi++) begin : g_cfg
            cci_cfg_t e;
            logic     sid_eq;
            logic     in_rng;
            logic     ctx;
            assign e      = st_ff.cfg[gi];
            assign sid_eq = (e.sid == st_ff.sid);
            assign in_rng = ((e.sid ^ st_ff.sid) & rmask[31:0]) == 32'h0000_0000;
            assign ctx    = (e.kind == K_CD) || (e.kind == K_CONTEXT_POINTER_DESCRIPTOR);
            always_comb begin
                cfg_hit[gi] = 1'b0;
                if (e.v && (e.sec == csel)) begin
                    case (op)
                        // one stream entry with its contexts and vm data
                        OP_STE:     cfg_hit[gi] = sid_eq && (!cleaf || e.kind != K_STREAM_POINTER_DESCRIPTOR);
                        OP_STE_RNG: cfg_hit[gi] = in_rng;
                        // full clear of the security state, no range walk
                        OP_ALL:     cfg_hit[gi] = 1'b1;
                        OP_CD:      cfg_hit[gi] = sid_eq && ((e.kind == K_CD && e.sub == csub)
                                                 || (e.kind == K_CONTEXT_POINTER_DESCRIPTOR && !cleaf));
                        OP_CD_ALL:  cfg_hit[gi] = sid_eq && ctx;
                        default:    cfg_hit[gi] = 1'b0;
                    endcase
                end
            end
        end
        for (gi = 0; gi < NPM; gi++) begin : g_pm
            // partition maps live apart from stream entry caching
            assign pm_hit[gi] = (op == OP_PMAP) && st_ff.pm[gi].v
                              && (st_ff.pm[gi].sec == csel)
                              && (st_ff.pm[gi].vm == cvm);
        end
        for (gi = 0; gi < NTLB; gi++) begin : g_tlb
            cci_tlb_t    t;
            logic        wc;
            logic        vm_ok;
            logic        as_ok;
            logic        va_ok;
            logic [31:0] amask;
            assign t     = st_ff.tlb[gi];
            assign wc    = t.sec ? st_ff.s_wild : st_ff.ns_wild;
            assign vm_ok = (t.wild && wc) || (t.vm == cvm);
            // shared-set flag is not part of the entry match
            assign as_ok = (t.address_space_tag == cas);
            assign amask = ~((32'd1 << t.size) - 32'd1);
            assign va_ok = ((t.addr ^ st_ff.addr) & amask) == 32'h0000_0000;
            always_comb begin
                tlb_hit[gi] = 1'b0;
                if (t.v && !t.lock && (t.sec == csel) && !tag_bad) begin
                    case (op)
                        OP_TLB_SEC: tlb_hit[gi] = 1'b1;
                        OP_TLB_VM:  tlb_hit[gi] = vm_ok;
                        OP_TLB_AS:  tlb_hit[gi] = vm_ok && as_ok;
                        OP_TLB_VA:  tlb_hit[gi] = vm_ok && as_ok && va_ok
                                                 && (!cleaf || t.leaf);
                        default:    tlb_hit[gi] = 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic        acc;
    logic        cmd_wr;
    logic        hold;
    logic        mapped;
    logic [31:0] rd_val;

    assign acc    = psel && penable;
    assign cmd_wr = pwrite && (paddr == REG_CMD0);
    // a new command waits until the previous one is consumed
    assign hold   = cmd_wr && (st_ff.ph != PH_IDLE);
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_CMD0) || (paddr == REG_SID)
                 || (paddr == REG_TAGS) || (paddr == REG_ADDR)
                 || (paddr == REG_STATUS) || (paddr == REG_ID);

    // read mux
    always_comb begin
        rd_val = RST_WORD;
        case (paddr)
            REG_CTRL: begin
                rd_val[CTRL_NS_WILD] = st_ff.ns_wild;
                rd_val[CTRL_S_WILD]  = st_ff.s_wild;
                rd_val[CTRL_SECQ]    = st_ff.secq;
            end
            REG_CMD0: rd_val = st_ff.cmd0;
            REG_SID:  rd_val = st_ff.sid;
            REG_TAGS: rd_val = st_ff.tags;
            REG_ADDR: rd_val = st_ff.addr;
            REG_STATUS: begin
                rd_val[ST_ERR]       = st_ff.err;
                rd_val[ST_BUSY]      = (st_ff.ph != PH_IDLE);
                rd_val[ST_SYNC +: 16] = st_ff.sync_cnt;
            end
            REG_ID: rd_val = {27'd0, STAGE1, VMID16, ASID16, RIL_SUP, PM_SUP};
            default: rd_val = RST_WORD;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync_pulse = 1'b0;
        // cache refill from the translation side
        if (fill_valid) begin
            if (fill_target == 2'd0 && 32'(fill_idx) < NCFG) begin
                nxt_st.cfg[fill_idx] = fill_cfg;
            end else if (fill_target == 2'd1 && 32'(fill_idx) < NPM) begin
                nxt_st.pm[fill_idx] = fill_pm;
            end else if (fill_target == 2'd2 && 32'(fill_idx) < NTLB) begin
                nxt_st.tlb[fill_idx] = fill_tlb;
            end
        end
        // apb: answer one cycle into access, act on the completing edge
        if (st_ff.rdy) begin
            nxt_st.rdy    = 1'b0;
            nxt_st.slverr = 1'b0;
            if (acc && pwrite && mapped) begin
                case (paddr)
                    REG_CTRL: begin
                        nxt_st.ns_wild = pwdata[CTRL_NS_WILD];
                        nxt_st.s_wild  = pwdata[CTRL_S_WILD];
                        nxt_st.secq    = pwdata[CTRL_SECQ];
                    end
                    REG_CMD0: begin
                        nxt_st.cmd0 = pwdata;
                        nxt_st.ph   = PH_EXEC;
                    end
                    REG_SID:  nxt_st.sid  = pwdata;
                    REG_TAGS: nxt_st.tags = pwdata;
                    REG_ADDR: nxt_st.addr = pwdata;
                    REG_STATUS: begin
                        if (pwdata[ST_ERR]) begin
                            nxt_st.err = 1'b0;
                        end
                    end
                    default: nxt_st.rdy = 1'b0;
                endcase
            end
        end else if (acc && !hold) begin
            nxt_st.rdy    = 1'b1;
            nxt_st.slverr = !mapped;
            nxt_st.rdata  = pwrite ? RST_WORD : rd_val;
        end
        // command engine; invalidations win over a same-cycle refill
        case (st_ff.ph)
            PH_IDLE: nxt_st.ph = nxt_st.ph;
            PH_EXEC: begin
                if (illegal) begin
                    nxt_st.err = 1'b1;
                    nxt_st.ph  = PH_IDLE;
                end else if (op == OP_SYNC) begin
                    nxt_st.ph = PH_SYNC;
                end else begin
                    // whole entries drop in one edge, never half valid
                    for (int i = 0; i < NCFG; i++) begin
                        if (cfg_hit[i]) begin
                            nxt_st.cfg[i].v = 1'b0;
                        end
                    end
                    for (int i = 0; i < NPM; i++) begin
                        if (pm_hit[i]) begin
                            nxt_st.pm[i].v = 1'b0;
                        end
                    end
                    // local tlb only; no maintenance leaves the block
                    for (int i = 0; i < NTLB; i++) begin
                        if (tlb_hit[i]) begin
                            nxt_st.tlb[i].v = 1'b0;
                        end
                    end
                    nxt_st.ph = PH_IDLE;
                end
            end
            PH_SYNC: begin
                // prior commands finished in order; wait for in-flight users
                // stalled transactions are not counted and stay untouched
                if (!xlat_inflight) begin
                    nxt_st.sync_pulse = 1'b1;
                    nxt_st.sync_cnt   = st_ff.sync_cnt + 16'd1;
                    nxt_st.ph         = PH_IDLE;
                end
            end
            default: nxt_st.ph = PH_IDLE;
        endcase
        // hardware set beats a same-cycle software clear
        if (st_ff.ph == PH_EXEC && illegal) begin
            nxt_st.err = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign prdata                = st_ff.rdata;
    assign pready                = st_ff.rdy;
    assign pslverr               = st_ff.slverr;
    assign illegal_command_error = st_ff.err;
    assign sync_done             = st_ff.sync_pulse;

    // valid bitmaps of the three caches
    generate
        for (gi = 0; gi < NCFG; gi++) begin : g_vc
            assign cfg_valid[gi] = st_ff.cfg[gi].v;
        end
        for (gi = 0; gi < NPM; gi++) begin : g_vp
            assign pm_valid[gi] = st_ff.pm[gi].v;
        end
        for (gi = 0; gi < NTLB; gi++) begin : g_vt
            assign tlb_valid[gi] = st_ff.tlb[gi].v;
        end
    endgenerate
endmodule : cci_inval
`default_nettype wire

// [dv/cci_inval_monitor.sv]
// port checker for the invalidation block
`timescale 1ns/1ps
`default_nettype none
module cci_inval_monitor
    import cci_pkg::*;
#(
    parameter int NCFG = 8,
    parameter int NPM  = 4
) (
    input wire logic            pclk,
    input wire logic            presetn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [7:0]      paddr,
    input wire logic [31:0]     pwdata,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic            fill_valid,
    input wire logic            xlat_inflight,
    input wire logic [NCFG-1:0] cfg_valid,
    input wire logic [NPM-1:0]  pm_valid,
    input wire logic            illegal_command_error,
    input wire logic            sync_done
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    // an accepted write at this edge
    assign acc = psel && penable && pready && pwrite;
    sequence cmd_seq(logic [7:0] op);
        acc && paddr == REG_CMD0 && pwdata[7:0] == op;
    endsequence
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_ready_access: assert property (pready |-> psel && penable) else $error("stray pready");
    a_unmapped_err: assert property (psel && penable && pready && paddr > REG_ID |-> pslverr)
        else $error("unmapped access without slave error");
    a_err_sticky: assert property (illegal_command_error
        && !(acc && paddr == REG_STATUS && pwdata[ST_ERR]) |=> illegal_command_error)
        else $error("error flag lost");
    a_sync_wait: assert property (xlat_inflight |=> !sync_done)
        else $error("sync done while traffic pending");
    a_cfg_no_grow: assert property (!fill_valid |=> (cfg_valid & ~$past(cfg_valid)) == '0)
        else $error("entry became valid without fill");
    a_pm_kept: assert property (cmd_seq(OP_STE_RNG) |=> $stable(pm_valid)[*3])
        else $error("stream invalidation touched partition maps");
    a_err_no_clear: assert property ($rose(illegal_command_error)
        |-> cfg_valid == $past(cfg_valid, 2)) else $error("refused command cleared entries");
endmodule : cci_inval_monitor
bind cci_inval cci_inval_monitor #(.NCFG(NCFG), .NPM(NPM)) cci_inval_monitor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .fill_valid(fill_valid), .xlat_inflight(xlat_inflight), .cfg_valid(cfg_valid),
    .pm_valid(pm_valid), .illegal_command_error(illegal_command_error),
    .sync_done(sync_done));
`default_nettype wire

// [dv/cci_xlat_model.sv]
// in-flight translation traffic that has used cached structures
`timescale 1ns/1ps
`default_nettype none
module cci_xlat_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic [7:0] hold,
    output logic            xlat_inflight
);
    logic [7:0] cnt_ff;
    // traffic stays pending for hold cycles after start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_ff <= 8'h00;
        else if (start) cnt_ff <= hold;
        else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
    end
    assign xlat_inflight = cnt_ff != 8'h00;
endmodule : cci_xlat_model
`default_nettype wire

// [dv/config_cache_invalidation_test.sv]
// self-checking bench for the invalidation block
`timescale 1ns/1ps
`default_nettype none
module config_cache_invalidation_test;
    import cci_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, fill_idx = 8'h00, hold = 8'h00, cfg_valid, tlb_valid;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic pready, pslverr, fill_valid = 1'b0, start = 1'b0, xlat_inflight, err, sdone, e;
    logic [1:0] fill_target = 2'h0;
    logic [3:0] pm_valid;
    cci_cfg_t fill_cfg = '0;
    cci_pm_t fill_pm = '0;
    cci_tlb_t fill_tlb = '0;
    int failures = 0, checks = 0;
    cci_inval cci_inval_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fill_valid(fill_valid), .fill_target(fill_target),
        .fill_idx(fill_idx), .fill_cfg(fill_cfg), .fill_pm(fill_pm), .fill_tlb(fill_tlb),
        .xlat_inflight(xlat_inflight), .cfg_valid(cfg_valid), .pm_valid(pm_valid),
        .tlb_valid(tlb_valid), .illegal_command_error(err), .sync_done(sdone));
    cci_xlat_model cci_xlat_model_i (.pclk(pclk), .presetn(presetn), .start(start),
        .hold(hold), .xlat_inflight(xlat_inflight));
    // free-running clock
    always #5 pclk = ~pclk;
    function automatic logic [31:0] cw(input logic [7:0] op, input logic s, input logic [4:0] g);
        return {17'h0, g, 1'b0, s, op};
    endfunction : cw
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(n < 100, 1);
    endtask : apb
    task automatic cmd(input logic [31:0] d);
        apb(1'b1, REG_CMD0, d);
        repeat (3) @(posedge pclk);
        #1;
    endtask : cmd
    task automatic fill_all();
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            fill_valid <= 1'b1;
            fill_idx <= 8'(i);
            fill_cfg <= '{1'b1, i[0], (i == 7) ? K_VMS : {1'b0, 2'(i)}, i, 20'h0};
            fill_pm <= '{1'b1, i[0], 16'(i[1:0])};
            fill_tlb <= '{1'b1, i[0], i == 6, 1'b1, 1'b0, 16'(i[2:1]), 16'h0001,
                32'h1000_0000, 5'h0c};
            for (int t = 0; t < 3; t++) begin
                fill_target <= 2'(t);
                @(posedge pclk);
            end
            fill_valid <= 1'b0;
        end
        @(posedge pclk);
    endtask : fill_all
    task automatic sync(input logic [7:0] h);
        int n;
        n = 0;
        @(posedge pclk);
        start <= 1'b1;
        hold <= h;
        @(posedge pclk);
        start <= 1'b0;
        apb(1'b1, REG_CMD0, cw(OP_SYNC, 1'b0, 5'h0));
        while (sdone !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk(n < 200, 1);
        chk(n, (h > 8'd5) ? 32'(h) - 32'd2 : 32'd3);
    endtask : sync
    task automatic t_reset();
        chk({cfg_valid, tlb_valid, pm_valid, err, sdone}, 0);
        apb(1'b0, REG_ID, 0);
        chk(r, 32'h0000_001f);
        apb(1'b0, 8'h40, 0);
        chk(r, 32'h0000_0000);
        chk(e, 1);
        $display("reset test done");
    endtask : t_reset
    task automatic t_pmap();
        fill_all();
        apb(1'b1, REG_TAGS, 32'h0000_0002);
        cmd(cw(OP_PMAP, 1'b0, 5'h0));
        chk({pm_valid, cfg_valid}, {4'b1011, 8'hff});
        sync(8'h0);
        apb(1'b1, REG_SID, 32'h0000_0002);
        cmd(cw(OP_STE, 1'b0, 5'h0));
        chk(cfg_valid, 8'hfb);
        sync(8'h0);
        $display("partition map test done");
    endtask : t_pmap
    task automatic t_illegal();
        logic [31:0] bad [3] = '{cw(OP_ALL, 1'b1, 5'h0), cw(OP_PMAP, 1'b1, 5'h0), 32'h7f};
        foreach (bad[i]) begin
            cmd(bad[i]);
            chk({err, cfg_valid}, {1'b1, 8'hfb});
            apb(1'b1, REG_STATUS, 32'h0000_0001);
            #1;
            chk(err, 0);
        end
        $display("illegal command test done");
    endtask : t_illegal
    task automatic t_range();
        fill_all();
        apb(1'b1, REG_SID, 32'h0000_0004);
        cmd(cw(OP_STE_RNG, 1'b0, 5'h0));
        chk(cfg_valid, 8'hef);
        apb(1'b1, REG_SID, 32'h0000_1234);
        cmd(cw(OP_ALL, 1'b0, 5'h0));
        chk({cfg_valid, tlb_valid}, {8'haa, 8'hff});
        apb(1'b1, REG_CTRL, 32'h0000_0004);
        cmd(cw(OP_STE_RNG, 1'b1, RANGE_ALL));
        chk({err, cfg_valid}, 0);
        apb(1'b1, REG_CTRL, 32'h0000_0000);
        $display("range test done");
    endtask : t_range
    task automatic t_tlb();
        fill_all();
        apb(1'b1, REG_TAGS, 32'h0001_0001);
        cmd(cw(OP_TLB_VM, 1'b0, 5'h0));
        chk(tlb_valid, 8'hfb);
        apb(1'b1, REG_TAGS, 32'h0001_0003);
        cmd(cw(OP_TLB_VM, 1'b0, 5'h0));
        chk(tlb_valid, 8'hfb);
        apb(1'b1, REG_TAGS, 32'h0001_0002);
        apb(1'b1, REG_ADDR, 32'h1000_0abc);
        cmd(cw(OP_TLB_VA, 1'b0, 5'h0));
        chk({tlb_valid, cfg_valid}, {8'heb, 8'hff});
        $display("tlb test done");
    endtask : t_tlb
    task automatic t_sync();
        sync(8'd20);
        apb(1'b0, REG_STATUS, 0);
        chk(r[31:16], 16'h0003);
        $display("sync test done");
    endtask : t_sync
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_pmap();
        t_illegal();
        t_range();
        t_tlb();
        t_sync();
        print_verdict();
    end
    // watchdog
    initial begin
        #100us;
        failures++;
        print_verdict();
    end
endmodule : config_cache_invalidation_test
`default_nettype wire
